/* inc/urdc_pkg.sv */
// Constants and types shared by the USB reset and DMA request control block
package urdc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_DMA_SEL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Control register layout and reset value
  localparam int CTL_CORE_RST_BIT = 0;
  localparam int CTL_IFC_RST_BIT = 1;
  localparam int CTL_CLK_SEL_LSB = 2;
  localparam int CTL_CLK_SEL_W = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h03;
  localparam logic [3:0] CLK_SEL_PLL_OFF = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // DMA request select layout and reset value
  localparam int EP1_SEL_LSB = 0;
  localparam int EP2_SEL_LSB = 2;
  localparam logic [7:0] DMA_SEL_RESET = 8'h00;
  localparam logic [7:0] DMA_SEL_WR_MASK = 8'h0f;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_LINE0 = 2'h2;
  localparam logic [1:0] SEL_LINE1 = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Status register layout
  localparam int STS_CLK_READY_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Operating clock stabilisation time
  localparam int STAB_TIME_US = 2000;
  localparam int CLK_MHZ = 25;
  localparam int STAB_CYCLES = STAB_TIME_US * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // Stabilisation timer states
  typedef enum logic [1:0] {
    URDC_STAB_IDLE = 2'b00,
    URDC_STAB_COUNT = 2'b01,
    URDC_STAB_READY = 2'b10
  } urdc_stab_state_t;

endpackage

/* core/urdc_req_route.sv */
// Routes one endpoint's DMA request onto one of two request lines
module urdc_req_route (
  input wire logic [1:0] sel,
  input wire logic ep_req,
  output logic to_line0,
  output logic to_line1
);

  // Reserved code 01 behaves like 00: no request at all
  always_comb
  begin
    to_line0 = ep_req && (sel == urdc_pkg::SEL_LINE0); // R9 R10 R15
    to_line1 = ep_req && (sel == urdc_pkg::SEL_LINE1); // R9 R10 R15
  end

endmodule

/* core/urdc_stab_timer.sv */
// Operating clock stabilisation timer driving the clock-ready flag
module urdc_stab_timer #(
  parameter int CYCLES = urdc_pkg::STAB_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pll_run,
  output logic ready
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  urdc_pkg::urdc_stab_state_t state_reg;
  logic [CW-1:0] count_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Any drop of the PLL run level restarts the wait from zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= urdc_pkg::URDC_STAB_IDLE;
      count_reg <= '0;
    end
    else if (!pll_run)
    begin
      state_reg <= urdc_pkg::URDC_STAB_IDLE;
      count_reg <= '0;
    end
    else
    begin
      case (state_reg)
        urdc_pkg::URDC_STAB_IDLE:
        begin
          state_reg <= urdc_pkg::URDC_STAB_COUNT;
          count_reg <= '0;
        end
        urdc_pkg::URDC_STAB_COUNT:
        begin
          if (count_reg == LAST) // R14
            state_reg <= urdc_pkg::URDC_STAB_READY;
          else
            count_reg <= count_reg + CW'(1);
        end
        urdc_pkg::URDC_STAB_READY:
          state_reg <= urdc_pkg::URDC_STAB_READY;
        default:
          state_reg <= urdc_pkg::URDC_STAB_IDLE;
      endcase
    end
  end

  // Flag only after the full count
  assign ready = (state_reg == urdc_pkg::URDC_STAB_READY); // R14

  stab_ready_a: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    $rose(ready) |-> $past(count_reg) == LAST && $past(pll_run))
    else $error("clock ready rose before the full wait");

  stab_restart_a: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    !pll_run |=> !ready ##1 !ready)
    else $error("clock ready set without a running PLL");

endmodule

/* core/urdc_top.sv */
// AHB-Lite register bank for USB soft resets and DMA request routing
// Overview of operation
// R1: Interface reset bit holds USB modules in reset, except control and ready flag.
// R2: Both soft reset bits come up as 1 after reset.
// R3: Software clears interface reset only after clock stabilisation time.
// R4: Software re-setting interface reset also sets core reset together.
// R5: Core reset bit holds the controller core and stops bus sync.
// R6: Software clears core reset only after the pull-up is enabled.
// R7: In suspend software keeps core reset at 0, then stops module.
// R8: Software sets core reset after bus supply disconnect.
// R9: Endpoint-2 select: 00 none, 10 line 0, 11 line 1.
// R10: Endpoint-1 select: 00 none, 10 line 0, 11 line 1.
// R11: Select register bits 7 to 4 read zero, ignore writes.
// R12: Software gives the two endpoints different request lines.
// R13: Software writes zero to select register for DMA auto-request.
// R14: Clock ready flag rises 2 ms after the PLL starts.
// R15: Reserved select code 01 issues no request.
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
module urdc_top #(
  parameter int STAB_CYCLES = urdc_pkg::STAB_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic usb_module_stop_bit,
  input wire logic ep1_dma_req,
  input wire logic ep2_dma_req,
  output logic usb_ifc_reset,
  output logic usb_core_reset,
  output logic bus_sync_enable,
  output logic op_clock_ready_flag,
  output logic dma_request_line_0,
  output logic dma_request_line_1
);

  logic [7:0] usb_control_reg;
  logic [7:0] usb_dma_request_select_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] addr_reg;
  logic addr_phase;
  logic pll_run;
  logic ep1_l0, ep1_l1, ep2_l0, ep2_l1;
  logic line0_next, line1_next;
  logic line0_reg, line1_reg;
  logic boot_reg;
  logic [1:0] ep1_sel, ep2_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel && hready && htrans[1];

  // Address phase capture; only the low byte of the address decodes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_reg <= addr_phase && hwrite;
      rd_pend_reg <= addr_phase && !hwrite;
      addr_reg <= haddr[7:0];
    end
  end

  // Control register; soft reset bits come up set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      usb_control_reg <= urdc_pkg::CONTROL_RESET; // R2
    else if (wr_pend_reg && addr_reg == urdc_pkg::ADDR_CONTROL)
      usb_control_reg <= hwdata[7:0];
  end

  // Select register; upper nibble can never be written
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      usb_dma_request_select_reg <= urdc_pkg::DMA_SEL_RESET;
    else if (wr_pend_reg && addr_reg == urdc_pkg::ADDR_DMA_SEL)
      usb_dma_request_select_reg <= hwdata[7:0] &
        urdc_pkg::DMA_SEL_WR_MASK; // R11
  end

  // Read mux from registered state; unmapped offsets read zero
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (rd_pend_reg)
    begin
      case (addr_reg)
        urdc_pkg::ADDR_CONTROL:
          hrdata[7:0] = usb_control_reg;
        urdc_pkg::ADDR_DMA_SEL:
          hrdata[7:0] = usb_dma_request_select_reg; // R11
        urdc_pkg::ADDR_STATUS:
          hrdata[urdc_pkg::STS_CLK_READY_BIT] = op_clock_ready_flag;
        default:
          hrdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset outputs to the USB logic
  assign usb_ifc_reset = usb_control_reg[urdc_pkg::CTL_IFC_RST_BIT]; // R1
  assign usb_core_reset = usb_control_reg[urdc_pkg::CTL_CORE_RST_BIT]; // R5
  assign bus_sync_enable = !usb_core_reset; // R5

  ////////////////////////////////////////////////////////////////////////////
  // PLL runs once a clock is chosen and the module is not stopped.
  // The timer ignores the interface reset so the flag survives it.
  assign pll_run = !usb_module_stop_bit &&
    (usb_control_reg[urdc_pkg::CTL_CLK_SEL_LSB +: urdc_pkg::CTL_CLK_SEL_W]
     != urdc_pkg::CLK_SEL_PLL_OFF);

  urdc_stab_timer #(
    .CYCLES(STAB_CYCLES)
  ) u_stab (
    .hclk(hclk),
    .hresetn(hresetn),
    .pll_run(pll_run),
    .ready(op_clock_ready_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Endpoint request routing, one instance per endpoint
  assign ep1_sel = usb_dma_request_select_reg[urdc_pkg::EP1_SEL_LSB +: 2];
  assign ep2_sel = usb_dma_request_select_reg[urdc_pkg::EP2_SEL_LSB +: 2];

  urdc_req_route u_ep1 (
    .sel(ep1_sel),
    .ep_req(ep1_dma_req),
    .to_line0(ep1_l0),
    .to_line1(ep1_l1)
  );

  urdc_req_route u_ep2 (
    .sel(ep2_sel),
    .ep_req(ep2_dma_req),
    .to_line0(ep2_l0),
    .to_line1(ep2_l1)
  );

  // Interface reset silences the lines; shared lines simply merge
  assign line0_next = !usb_ifc_reset && (ep1_l0 || ep2_l0); // R1 R9 R10
  assign line1_next = !usb_ifc_reset && (ep1_l1 || ep2_l1); // R1 R9 R10

  // Registered so the DMA controller sees glitch-free requests
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      line0_reg <= 1'b0;
      line1_reg <= 1'b0;
    end
    else
    begin
      line0_reg <= line0_next;
      line1_reg <= line1_next;
    end
  end

  assign dma_request_line_0 = line0_reg;
  assign dma_request_line_1 = line1_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      boot_reg <= 1'b0;
    else
      boot_reg <= 1'b1;
  end

  reset_values_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    !boot_reg |-> usb_ifc_reset && usb_core_reset)
    else $error("soft resets not set after reset");

  ifc_write_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    wr_pend_reg && addr_reg == urdc_pkg::ADDR_CONTROL |=>
      usb_ifc_reset == $past(hwdata[urdc_pkg::CTL_IFC_RST_BIT]))
    else $error("interface reset did not follow write");

  ifc_gates_dma_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    usb_ifc_reset |=> !dma_request_line_0 && !dma_request_line_1)
    else $error("dma request while interface held in reset");

  core_sync_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    usb_core_reset != bus_sync_enable)
    else $error("bus sync running during core reset");

  ep2_route_a: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    ep2_sel == urdc_pkg::SEL_LINE0 && ep2_dma_req && !usb_ifc_reset |=>
      dma_request_line_0)
    else $error("ep2 request missing on line 0");

  ep1_route_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    ep1_sel == urdc_pkg::SEL_LINE1 && ep1_dma_req && !usb_ifc_reset |=>
      dma_request_line_1)
    else $error("ep1 request missing on line 1");

  reserved_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    rd_pend_reg && addr_reg == urdc_pkg::ADDR_DMA_SEL |->
      hrdata[31:4] == 28'h0000000)
    else $error("select register upper bits not zero");

  idle_code_a: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    !ep1_sel[1] && !ep2_sel[1] |=>
      !dma_request_line_0 && !dma_request_line_1)
    else $error("request issued for code 00 or 01");

  ////////////////////////////////////////////////////////////////////////////
  // Routing: each routed request shows, and nothing unrouted does
  ep2_line1_a: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    ep2_sel == urdc_pkg::SEL_LINE1 && ep2_dma_req && !usb_ifc_reset |=>
      dma_request_line_1)
    else $error("ep2 request missing on line 1");

  ep1_line0_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    ep1_sel == urdc_pkg::SEL_LINE0 && ep1_dma_req && !usb_ifc_reset |=>
      dma_request_line_0)
    else $error("ep1 request missing on line 0");

  no_request_a: assert property (@(posedge hclk) // R9 R10
    disable iff (!hresetn)
    !ep1_dma_req && !ep2_dma_req |=>
      !dma_request_line_0 && !dma_request_line_1)
    else $error("request line high with no request");

  line0_src_a: assert property (@(posedge hclk) // R9 R10
    disable iff (!hresetn)
    dma_request_line_0 |->
      $past(ep1_dma_req && ep1_sel == urdc_pkg::SEL_LINE0 ||
        ep2_dma_req && ep2_sel == urdc_pkg::SEL_LINE0))
    else $error("line 0 raised without a routed request");

  line1_src_a: assert property (@(posedge hclk) // R9 R10
    disable iff (!hresetn)
    dma_request_line_1 |->
      $past(ep1_dma_req && ep1_sel == urdc_pkg::SEL_LINE1 ||
        ep2_dma_req && ep2_sel == urdc_pkg::SEL_LINE1))
    else $error("line 1 raised without a routed request");

  ////////////////////////////////////////////////////////////////////////////
  // Register path: stored bits, write landing and read data
  sel_upper_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    usb_dma_request_select_reg[7:4] == 4'h0)
    else $error("select register upper bits stored");

  sel_write_a: assert property (@(posedge hclk) // R9 R10
    disable iff (!hresetn)
    wr_pend_reg && addr_reg == urdc_pkg::ADDR_DMA_SEL |=>
      ep1_sel == $past(hwdata[1:0]) && ep2_sel == $past(hwdata[3:2]))
    else $error("select codes did not follow write");

  core_write_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    wr_pend_reg && addr_reg == urdc_pkg::ADDR_CONTROL |=>
      usb_core_reset == $past(hwdata[urdc_pkg::CTL_CORE_RST_BIT]))
    else $error("core reset did not follow write");

  ctl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_reg && addr_reg == urdc_pkg::ADDR_CONTROL |=>
      usb_control_reg == $past(hwdata[7:0]))
    else $error("control register did not store write");

  ready_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    rd_pend_reg && addr_reg == urdc_pkg::ADDR_STATUS |->
      hrdata == {31'h0000_0000, op_clock_ready_flag})
    else $error("status read does not show clock ready");

  rdata_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_pend_reg |-> hrdata == 32'h0000_0000)
    else $error("read data outside a read data phase");

  sel_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !boot_reg |-> usb_dma_request_select_reg == urdc_pkg::DMA_SEL_RESET)
    else $error("select register not cleared by reset");

  ////////////////////////////////////////////////////////////////////////////
  // Timer and flag survive the interface reset, unlike the request lines
  timer_kept_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    usb_ifc_reset && pll_run && op_clock_ready_flag |=>
      op_clock_ready_flag)
    else $error("clock ready lost under interface reset");

endmodule

/* dv/urdc_core_model.sv */
// Behavioural USB core that raises bulk endpoint DMA requests
module urdc_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] want,
  input wire logic [3:0] lag,
  output logic ep1_dma_req,
  output logic ep2_dma_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Requests take the wanted level after a lag and all drop at once when want is zero, so slow cores are covered
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg <= 4'h0;
      ep1_dma_req <= 1'b0;
      ep2_dma_req <= 1'b0;
    end
    else if (want == 2'h0 || cnt_reg == lag)
    begin
      cnt_reg <= 4'h0;
      ep1_dma_req <= want[0];
      ep2_dma_req <= want[1];
    end
    else
      cnt_reg <= cnt_reg + 4'h1;
  end
endmodule

/* dv/tb.sv */
// Self-checking bench for the USB reset and DMA request control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic stop = 1'b1;
  logic [1:0] want = 2'h0;
  logic [3:0] lag = 4'h0;
  logic hready, hresp, ep1, ep2, ifc_rst, core_rst, sync, rdy, l0, l1;
  logic [31:0] hrdata, rd_q, q;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  localparam int STAB = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Short stabilisation count keeps the run brief
  urdc_top #(.STAB_CYCLES(STAB)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .usb_module_stop_bit(stop),
    .ep1_dma_req(ep1), .ep2_dma_req(ep2), .usb_ifc_reset(ifc_rst),
    .usb_core_reset(core_rst), .bus_sync_enable(sync),
    .op_clock_ready_flag(rdy), .dma_request_line_0(l0),
    .dma_request_line_1(l1));
  urdc_core_model i_core (.hclk(hclk), .hresetn(hresetn), .want(want),
    .lag(lag), .ep1_dma_req(ep1), .ep2_dma_req(ep2));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, read capture before the edge moves hrdata, and hang limit
  always #20 hclk = ~hclk;
  always @(posedge hclk)
    rd_q <= hrdata;
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One single word transfer; returns just after the data phase edge
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    #1 q = rd_q;
  endtask

  task automatic tick(int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    tick(1);
    chk("ifc_rst", ifc_rst, 1);
    chk("core_rst", core_rst, 1);
    chk("sync", sync, 0);
    xfer(1'b0, urdc_pkg::ADDR_CONTROL, 0);
    chk("control", q, 32'h3);
    chk("okay", {hready, hresp}, 32'h2);
    $display("test reset done");
    xfer(1'b1, urdc_pkg::ADDR_DMA_SEL, 32'hff);
    xfer(1'b0, urdc_pkg::ADDR_DMA_SEL, 0);
    chk("dma_sel", q, 32'hf);
    xfer(1'b0, 8'h10, 0);
    chk("unmapped", q, 0);
    xfer(1'b1, urdc_pkg::ADDR_DMA_SEL, 0);
    $display("test registers done");
    // Clock select written while stopped, then the module is started
    xfer(1'b1, urdc_pkg::ADDR_CONTROL, 32'h1b);
    stop <= 1'b0;
    n = 0;
    while (rdy !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk("ready_at", n, STAB + 1);
    xfer(1'b0, urdc_pkg::ADDR_STATUS, 0);
    chk("status", q, 1);
    xfer(1'b1, urdc_pkg::ADDR_CONTROL, 32'h19);
    chk("ifc_rst", ifc_rst, 0);
    xfer(1'b1, urdc_pkg::ADDR_CONTROL, 32'h18);
    chk("core_rst", core_rst, 0);
    chk("sync", sync, 1);
    // Suspend: core reset stays clear while the module is stopped
    stop <= 1'b1;
    tick(2);
    chk("susp_core", core_rst, 0);
    chk("susp_rdy", rdy, 0);
    stop <= 1'b0;
    $display("test bring_up done");
    // Every code for each endpoint alone, other endpoint unrouted
    for (int e = 0; e < 2; e++)
      for (int c = 0; c < 4; c++)
      begin
        xfer(1'b1, urdc_pkg::ADDR_DMA_SEL, 32'(c) << (2 * e));
        lag <= 4'(2 * c);
        want <= 2'(e + 1);
        tick(10);
        chk("line0", l0, c == 2);
        chk("line1", l1, c == 3);
        want <= 2'h0;
        tick(4);
        chk("idle", {l1, l0}, 0);
      end
    xfer(1'b1, urdc_pkg::ADDR_DMA_SEL, 32'he);
    want <= 2'h3;
    tick(10);
    chk("both", {l1, l0}, 3);
    $display("test routing done");
    // Interface reset again, core reset in the same write
    xfer(1'b1, urdc_pkg::ADDR_CONTROL, 32'h1b);
    chk("ifc_rst", ifc_rst, 1);
    tick(3);
    chk("gated", {l1, l0}, 0);
    chk("rdy_kept", rdy, 1);
    want <= 2'h0;
    xfer(1'b1, urdc_pkg::ADDR_DMA_SEL, 0);
    xfer(1'b0, urdc_pkg::ADDR_DMA_SEL, 0);
    chk("dma_sel", q, 0);
    stop <= 1'b1;
    tick(3);
    chk("rdy_off", rdy, 0);
    $display("test shutdown done");
    stop_test();
  end
endmodule
